// ### core/pdsc_cfg.sv
`timescale 1ns/1ns
module pdsc_cfg
  import pdsc_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic        WR_STB,
  input  wire logic [31:0] WR_DATA,
  input  wire logic        RD_STB,
  output logic      [31:0] RD_DATA,
  output logic             RD_ACK,
  output logic             CMD_INVALID,
  output logic      [6:0]  COEF_INT,
  output logic      [6:0]  COEF_EXT0,
  output logic      [6:0]  COEF_EXT1,
  input  wire logic        HL_STEP_UP,
  input  wire logic        HL_STEP_DN,
  input  wire logic        LH_STEP_UP,
  input  wire logic        LH_STEP_DN,
  output pdsc_gap_s        HL_GAP,
  output pdsc_gap_s        LH_GAP,
  output logic             LOOP_EN,
  output logic      [15:0] LOOP_GAIN,
  output logic      [7:0]  LOOP_RESIDUAL,
  input  wire logic        ENABLE_REQ,
  input  pdsc_gevt_s       GROUP_EVT,
  output logic             OUTPUT_EN
);

  logic [7:0]  temp_corr;
  logic [15:0] gap_times;
  logic [15:0] gap_opt;
  logic [31:0] loop_cfg;
  logic [15:0] order;
  logic        gap_prev;
  logic        load_max;
  logic        code_ok;
  logic [31:0] rd_mux;
  logic        wr_corr;
  logic        wr_gt;
  logic        wr_go;
  logic        wr_lp;
  logic        wr_sq;
  logic        pre_en;
  logic        nxt_en;
  logic [4:0]  pre_id;
  logic [4:0]  nxt_id;
  logic        pre_pg_evt;
  logic        pre_pd_evt;
  logic        nxt_pd_evt;
  logic        prequel_good;
  logic        held_off;
  pdsc_rail_e  state;
  pdsc_rail_e  next_state;

  // ==========================================================================
  // command decode
  always_comb begin
    unique case (CMD_CODE)
      CMD_TEMP_CORR: begin
        code_ok = 1'b1;
        rd_mux  = {24'h00_0000, temp_corr};
      end
      CMD_GAP_TIMES: begin
        code_ok = 1'b1;
        rd_mux  = {16'h0000, gap_times};
      end
      CMD_GAP_OPT: begin
        code_ok = 1'b1;
        rd_mux  = {16'h0000, gap_opt};
      end
      CMD_LOOP: begin
        code_ok = 1'b1;
        rd_mux  = loop_cfg;
      end
      CMD_ORDER: begin
        code_ok = 1'b1;
        rd_mux  = {16'h0000, order};
      end
      default: begin
        code_ok = 1'b0;
        rd_mux  = 32'h0000_0000;
      end
    endcase
  end

  assign wr_corr = WR_STB && (CMD_CODE == CMD_TEMP_CORR);
  assign wr_gt = WR_STB && (CMD_CODE == CMD_GAP_TIMES);
  assign wr_go = WR_STB && (CMD_CODE == CMD_GAP_OPT);
  assign wr_lp = WR_STB && (CMD_CODE == CMD_LOOP);
  assign wr_sq = WR_STB && (CMD_CODE == CMD_ORDER);

  // ==========================================================================
  // configuration registers
  // masked writes
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      temp_corr <= RST_TEMP_CORR;
    end else if (wr_corr) begin
      temp_corr <= WR_DATA[7:0] & MASK_TEMP_CORR[7:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      gap_times <= RST_GAP_TIMES;
    end else if (wr_gt) begin
      gap_times <= WR_DATA[15:0] & MASK_GAP_TIMES[15:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      gap_opt <= RST_GAP_OPT;
    end else if (wr_go) begin
      gap_opt <= WR_DATA[15:0] & MASK_GAP_OPT[15:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      loop_cfg <= RST_LOOP;
    end else if (wr_lp) begin
      loop_cfg <= WR_DATA & MASK_LOOP;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      order <= RST_ORDER;
    end else if (wr_sq) begin
      order <= WR_DATA[15:0] & MASK_ORDER[15:0];
    end
  end

  // ==========================================================================
  // read path and error answer
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      RD_DATA     <= 32'h0000_0000;
      RD_ACK      <= 1'b0;
      CMD_INVALID <= 1'b0;
    end else begin
      RD_ACK      <= RD_STB && code_ok;
      CMD_INVALID <= (RD_STB || WR_STB) && !code_ok;
      if (RD_STB) begin
        RD_DATA <= rd_mux;
      end
    end
  end

  // ==========================================================================
  // dead-time ceiling capture
  // back-to-back write order
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      gap_prev <= 1'b0;
    end else if (WR_STB) begin
      gap_prev <= (CMD_CODE == CMD_GAP_TIMES);
    end
  end

  assign load_max = wr_go && gap_prev;

  // ==========================================================================
  // current-sense correction outputs
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      COEF_INT  <= 7'h00;
      COEF_EXT0 <= 7'h00;
      COEF_EXT1 <= 7'h00;
    end else if (temp_corr[CORR_SRC_BIT]) begin
      COEF_INT  <= 7'h00;
      COEF_EXT0 <= temp_corr[CORR_COEF_LSB +: 7];
      COEF_EXT1 <= temp_corr[CORR_COEF_LSB +: 7];
    end else begin
      COEF_INT  <= temp_corr[CORR_COEF_LSB +: 7];
      COEF_EXT0 <= 7'h00;
      COEF_EXT1 <= 7'h00;
    end
  end

  // ==========================================================================
  // dead-time channels
  // high-to-low mode
  pdsc_gap_chan u_hl (
    .CLOCK     (CLOCK),
    .RST_B     (RST_B),
    .WRITTEN   ($signed(gap_times[GT_HL_LSB +: 8])),
    .FREEZE    (gap_opt[GO_HL_FREEZE]),
    .MIN_UNITS ($signed(gap_opt[GO_HL_MIN_LSB +: 7])),
    .LOAD_MAX  (load_max),
    .STEP_UP   (HL_STEP_UP),
    .STEP_DN   (HL_STEP_DN),
    .GAP       (HL_GAP)
  );

  pdsc_gap_chan u_lh (
    .CLOCK     (CLOCK),
    .RST_B     (RST_B),
    .WRITTEN   ($signed(gap_times[GT_LH_LSB +: 8])),
    .FREEZE    (gap_opt[GO_LH_FREEZE]),
    .MIN_UNITS ($signed(gap_opt[GO_LH_MIN_LSB +: 7])),
    .LOAD_MAX  (load_max),
    .STEP_UP   (LH_STEP_UP),
    .STEP_DN   (LH_STEP_DN),
    .GAP       (LH_GAP)
  );

  // ==========================================================================
  // adaptive loop settings
  // loop enable bit
  assign LOOP_EN       = loop_cfg[LP_EN_BIT];
  assign LOOP_GAIN     = loop_cfg[LP_GAIN_LSB +: 16];
  assign LOOP_RESIDUAL = loop_cfg[LP_RES_LSB +: 8];

  // ==========================================================================
  // rail sequencing
  // dependency enables
  assign pre_en = order[SQ_PRE_EN];
  assign nxt_en = order[SQ_NXT_EN];
  assign pre_id = order[SQ_PRE_ID_LSB +: 5];
  assign nxt_id = order[SQ_NXT_ID_LSB +: 5];

  assign pre_pg_evt = GROUP_EVT.valid && (GROUP_EVT.id == pre_id) && GROUP_EVT.power_good;
  assign pre_pd_evt = GROUP_EVT.valid && (GROUP_EVT.id == pre_id) && !GROUP_EVT.power_good;
  assign nxt_pd_evt = GROUP_EVT.valid && (GROUP_EVT.id == nxt_id) && !GROUP_EVT.power_good;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      prequel_good <= 1'b0;
    end else if (pre_pg_evt) begin
      prequel_good <= 1'b1;
    end else if (pre_pd_evt) begin
      prequel_good <= 1'b0;
    end
  end

  // a rail shut off by its follower stays off until its enable drops
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      held_off <= 1'b0;
    end else if (nxt_en && nxt_pd_evt && state == RAIL_ON) begin
      held_off <= 1'b1;
    end else if (!ENABLE_REQ) begin
      held_off <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      RAIL_OFF: begin
        if (ENABLE_REQ && !held_off) begin
          next_state = (pre_en && !prequel_good) ? RAIL_WAIT : RAIL_ON;
        end
      end
      RAIL_WAIT: begin
        if (!ENABLE_REQ) begin
          next_state = RAIL_OFF;
        end else if (!pre_en || prequel_good) begin
          next_state = RAIL_ON;
        end
      end
      RAIL_ON: begin
        if (!ENABLE_REQ) begin
          next_state = RAIL_OFF;
        end else if (nxt_en && nxt_pd_evt) begin
          next_state = RAIL_OFF;
        end
      end
      default: begin
        next_state = RAIL_OFF;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state <= RAIL_OFF;
    end else begin
      state <= next_state;
    end
  end

  assign OUTPUT_EN = (state == RAIL_ON);

  // ==========================================================================
  // checks
  property p_ext_coef;
    @(posedge CLOCK) disable iff (!RST_B)
    temp_corr[CORR_SRC_BIT] |=> (COEF_EXT0 == $past(temp_corr[6:0]))
      && (COEF_EXT1 == COEF_EXT0) && (COEF_INT == 7'h00);
  endproperty
  a_ext_coef: assert property (p_ext_coef) else $error("external coefficient wrong");
  property p_loop_rsv;
    @(posedge CLOCK) disable iff (!RST_B)
    (RD_STB && CMD_CODE == CMD_LOOP) |=> (RD_ACK && RD_DATA[31:25] == 7'h00);
  endproperty
  a_loop_rsv: assert property (p_loop_rsv) else $error("reserved bits not zero");
  property p_gap_write;
    @(posedge CLOCK) disable iff (!RST_B)
    wr_gt |=> (gap_times == $past(WR_DATA[15:0]));
  endproperty
  a_gap_write: assert property (p_gap_write) else $error("dead-time word not stored");
  property p_max_order;
    @(posedge CLOCK) disable iff (!RST_B)
    wr_gt ##1 wr_go |-> load_max;
  endproperty
  a_max_order: assert property (p_max_order) else $error("ceiling load missed");
  property p_loop_fields;
    @(posedge CLOCK) disable iff (!RST_B)
    wr_lp |=> (LOOP_GAIN == $past(WR_DATA[15:0])) && (LOOP_EN == $past(WR_DATA[24]))
      && (LOOP_RESIDUAL == $past(WR_DATA[23:16]));
  endproperty
  a_loop_fields: assert property (p_loop_fields) else $error("loop fields wrong");
  property p_wait_prequel;
    @(posedge CLOCK) disable iff (!RST_B)
    (pre_en && !prequel_good && !OUTPUT_EN) |=> !OUTPUT_EN;
  endproperty
  a_wait_prequel: assert property (p_wait_prequel) else $error("enabled before prequel");
  property p_direct_on;
    @(posedge CLOCK) disable iff (!RST_B)
    (state == RAIL_OFF && ENABLE_REQ && !held_off && !pre_en) |=> OUTPUT_EN;
  endproperty
  a_direct_on: assert property (p_direct_on) else $error("direct enable missed");
  property p_sequel_off;
    @(posedge CLOCK) disable iff (!RST_B)
    (OUTPUT_EN && nxt_en && nxt_pd_evt) |=> !OUTPUT_EN [*2];
  endproperty
  a_sequel_off: assert property (p_sequel_off) else $error("sequel power-down ignored");

endmodule : pdsc_cfg

// ### core/pdsc_pkg.sv
package pdsc_pkg;

  // ==========================================================================
  // command codes
  localparam logic [7:0]  CMD_TEMP_CORR  = 8'hDC;
  localparam logic [7:0]  CMD_GAP_TIMES  = 8'hDD;
  localparam logic [7:0]  CMD_GAP_OPT    = 8'hDE;
  localparam logic [7:0]  CMD_LOOP       = 8'hDF;
  localparam logic [7:0]  CMD_ORDER      = 8'hE0;

  // ==========================================================================
  // writable bit masks, unassigned bits stay zero
  localparam logic [31:0] MASK_TEMP_CORR = 32'h0000_00FF;
  localparam logic [31:0] MASK_GAP_TIMES = 32'h0000_FFFF;
  localparam logic [31:0] MASK_GAP_OPT   = 32'h0000_FFFF;
  localparam logic [31:0] MASK_LOOP      = 32'h01FF_FFFF;
  localparam logic [31:0] MASK_ORDER     = 32'h0000_9F9F;

  // ==========================================================================
  // reset values
  localparam logic [7:0]  RST_TEMP_CORR  = 8'h00;
  localparam logic [15:0] RST_GAP_TIMES  = 16'h3C3C;
  localparam logic [15:0] RST_GAP_OPT    = 16'h0000;
  localparam logic [31:0] RST_LOOP       = 32'h0000_0000;
  localparam logic [15:0] RST_ORDER      = 16'h0000;

  // ==========================================================================
  // field positions
  localparam int CORR_COEF_LSB = 0;
  localparam int CORR_SRC_BIT  = 7;
  localparam int GT_HL_LSB     = 8;
  localparam int GT_LH_LSB     = 0;
  localparam int GO_HL_MIN_LSB = 8;
  localparam int GO_LH_MIN_LSB = 0;
  localparam int GO_HL_FREEZE  = 15;
  localparam int GO_LH_FREEZE  = 7;
  localparam int LP_GAIN_LSB   = 0;
  localparam int LP_RES_LSB    = 16;
  localparam int LP_EN_BIT     = 24;
  localparam int SQ_PRE_ID_LSB = 8;
  localparam int SQ_NXT_ID_LSB = 0;
  localparam int SQ_PRE_EN     = 15;
  localparam int SQ_NXT_EN     = 7;

  // ==========================================================================
  // dead-time limits in ns, minimum fields in 2 ns units
  localparam logic signed [7:0] GAP_LOW_NS      = -8'sd10;
  localparam logic signed [7:0] GAP_HIGH_NS     = 8'sd60;
  localparam logic signed [7:0] GAP_MAX_DFLT_NS = 8'sd60;
  localparam logic signed [6:0] OPT_MIN_LOW     = -7'sd5;
  localparam logic signed [6:0] OPT_MIN_HIGH    = 7'sd28;
  localparam logic signed [7:0] GAP_STEP_NS     = 8'sd1;

  // ==========================================================================
  // carriers and states
  typedef struct packed {
    logic       valid;
    logic [4:0] id;
    logic       power_good;
  } pdsc_gevt_s;

  typedef struct packed {
    logic signed [7:0] ns;
    logic              overlap;
  } pdsc_gap_s;

  typedef enum logic [1:0] {
    RAIL_OFF  = 2'b00,
    RAIL_WAIT = 2'b01,
    RAIL_ON   = 2'b11
  } pdsc_rail_e;

endpackage : pdsc_pkg

// ### core/pdsc_gap_chan.sv
`timescale 1ns/1ns
module pdsc_gap_chan
  import pdsc_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              RST_B,
  input  wire logic signed [7:0] WRITTEN,
  input  wire logic              FREEZE,
  input  wire logic signed [6:0] MIN_UNITS,
  input  wire logic              LOAD_MAX,
  input  wire logic              STEP_UP,
  input  wire logic              STEP_DN,
  output pdsc_gap_s              GAP
);

  logic signed [7:0] cur;
  logic signed [7:0] max_ns;
  logic signed [7:0] written_c;
  logic signed [6:0] min_u;
  logic signed [7:0] min_ns;
  logic signed [7:0] lower;
  logic signed [7:0] upper;

  // ==========================================================================
  // limits
  always_comb begin
    written_c = WRITTEN;
    if (WRITTEN < GAP_LOW_NS) begin
      written_c = GAP_LOW_NS;
    end else if (WRITTEN > GAP_HIGH_NS) begin
      written_c = GAP_HIGH_NS;
    end
    min_u = MIN_UNITS;
    if (MIN_UNITS < OPT_MIN_LOW) begin
      min_u = OPT_MIN_LOW;
    end else if (MIN_UNITS > OPT_MIN_HIGH) begin
      min_u = OPT_MIN_HIGH;
    end
    min_ns = $signed({min_u, 1'b0});
    lower  = (min_ns < GAP_LOW_NS) ? GAP_LOW_NS : min_ns;
    upper  = (max_ns < lower) ? lower : max_ns;
  end

  // ==========================================================================
  // adaptive ceiling
  // ceiling default
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      max_ns <= GAP_MAX_DFLT_NS;
    end else if (LOAD_MAX) begin
      max_ns <= written_c;
    end
  end

  // ==========================================================================
  // applied dead time
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      cur <= GAP_MAX_DFLT_NS;
    end else if (FREEZE) begin
      cur <= written_c;
    end else if (STEP_DN && cur > lower) begin
      cur <= cur - GAP_STEP_NS;
    end else if (STEP_UP && cur < upper) begin
      cur <= cur + GAP_STEP_NS;
    end else if (cur < lower) begin
      cur <= lower;
    end else if (cur > upper) begin
      cur <= upper;
    end
  end

  assign GAP.ns = cur;
  assign GAP.overlap = cur[7];

  // ==========================================================================
  // checks
  property p_frozen_follows;
    @(posedge CLOCK) disable iff (!RST_B)
    FREEZE |=> (cur == $past(written_c));
  endproperty
  a_frozen_follows: assert property (p_frozen_follows) else $error("frozen gap not written");

  property p_step_down;
    @(posedge CLOCK) disable iff (!RST_B)
    (!FREEZE && STEP_DN && cur > lower) |=> (cur == $past(cur) - GAP_STEP_NS);
  endproperty
  a_step_down: assert property (p_step_down) else $error("adaptive step down missed");

  property p_max_load;
    @(posedge CLOCK) disable iff (!RST_B)
    LOAD_MAX |=> (max_ns == $past(written_c));
  endproperty
  a_max_load: assert property (p_max_load) else $error("ceiling not taken");

  property p_overlap_sign;
    @(posedge CLOCK) disable iff (!RST_B)
    (FREEZE && written_c < 8'sd0) |=> GAP.overlap;
  endproperty
  a_overlap_sign: assert property (p_overlap_sign) else $error("overlap flag wrong");

endmodule : pdsc_gap_chan

// ### sim/pdsc_host_model.sv
`timescale 1ns/1ns
module pdsc_host_model
  import pdsc_pkg::*;
(
  input  wire logic        CLOCK,
  output logic      [7:0]  CMD_CODE,
  output logic             WR_STB,
  output logic      [31:0] WR_DATA,
  output logic             RD_STB,
  input  wire logic [31:0] RD_DATA,
  input  wire logic        RD_ACK,
  input  wire logic        CMD_INVALID,
  output pdsc_gevt_s       GROUP_EVT
);
  initial begin
    CMD_CODE  = 8'h00;
    WR_STB    = 1'b0;
    WR_DATA   = 32'h0000_0000;
    RD_STB    = 1'b0;
    GROUP_EVT = '0;
  end

  // ==========================================================================
  // command access, released lines carry the inverse of the last value
  task automatic wr(input logic [7:0] code, input logic [31:0] data);
    @(posedge CLOCK);
    CMD_CODE <= code;
    WR_STB   <= 1'b1;
    WR_DATA  <= data;
    @(posedge CLOCK);
    CMD_CODE <= ~code;
    WR_STB   <= 1'b0;
    WR_DATA  <= ~data;
  endtask : wr

  task automatic rd(input logic [7:0] code, output logic [31:0] data, output logic ack,
                    output logic inv);
    @(posedge CLOCK);
    CMD_CODE <= code;
    RD_STB   <= 1'b1;
    @(posedge CLOCK);
    CMD_CODE <= ~code;
    RD_STB   <= 1'b0;
    @(posedge CLOCK);
    data = RD_DATA;
    ack  = RD_ACK;
    inv  = CMD_INVALID;
  endtask : rd

  task automatic cap_max(input logic [15:0] gaps, input logic [15:0] opt);
    wr(CMD_GAP_TIMES, {16'h0000, gaps});
    wr(CMD_GAP_OPT, {16'h0000, opt});
  endtask : cap_max

  // ==========================================================================
  // peer rail event, at most one per cycle
  task automatic evt(input logic [4:0] id, input logic pg);
    @(posedge CLOCK);
    GROUP_EVT <= {1'b1, id, pg};
    @(posedge CLOCK);
    GROUP_EVT <= {1'b0, ~id, ~pg};
  endtask : evt

endmodule : pdsc_host_model

// ### sim/test_pdsc_cfg.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error %0t: got %h expected %h", $time, got, exp); end end
module test_pdsc_cfg
  import pdsc_pkg::*;
;
  logic        clock;
  logic        rst_b;
  logic [7:0]  cmd_code;
  logic        wr_stb;
  logic [31:0] wr_data;
  logic        rd_stb;
  logic [31:0] rd_data;
  logic        rd_ack;
  logic        cmd_invalid;
  logic [6:0]  coef_int;
  logic [6:0]  coef_ext0;
  logic [6:0]  coef_ext1;
  logic        hl_step_up;
  logic        hl_step_dn;
  logic        lh_step_up;
  logic        lh_step_dn;
  pdsc_gap_s   hl_gap;
  pdsc_gap_s   lh_gap;
  logic        loop_en;
  logic [15:0] loop_gain;
  logic [7:0]  loop_residual;
  logic        enable_req;
  pdsc_gevt_s  group_evt;
  logic        output_en;
  int          checks;
  int          n_mismatch;
  logic [7:0]  codes [5];
  logic [31:0] masks [5];
  logic [31:0] exp_reg [5];

  pdsc_cfg i_pdsc_cfg (.CLOCK(clock), .RST_B(rst_b), .CMD_CODE(cmd_code), .WR_STB(wr_stb),
    .WR_DATA(wr_data), .RD_STB(rd_stb), .RD_DATA(rd_data), .RD_ACK(rd_ack),
    .CMD_INVALID(cmd_invalid), .COEF_INT(coef_int), .COEF_EXT0(coef_ext0),
    .COEF_EXT1(coef_ext1), .HL_STEP_UP(hl_step_up), .HL_STEP_DN(hl_step_dn),
    .LH_STEP_UP(lh_step_up), .LH_STEP_DN(lh_step_dn), .HL_GAP(hl_gap), .LH_GAP(lh_gap),
    .LOOP_EN(loop_en), .LOOP_GAIN(loop_gain), .LOOP_RESIDUAL(loop_residual),
    .ENABLE_REQ(enable_req), .GROUP_EVT(group_evt), .OUTPUT_EN(output_en));

  pdsc_host_model i_pdsc_host_model (.CLOCK(clock), .CMD_CODE(cmd_code), .WR_STB(wr_stb),
    .WR_DATA(wr_data), .RD_STB(rd_stb), .RD_DATA(rd_data), .RD_ACK(rd_ack),
    .CMD_INVALID(cmd_invalid), .GROUP_EVT(group_evt));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ==========================================================================
  // helpers
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic chk_rd(input logic [7:0] code, input logic [31:0] exp);
    logic [31:0] d;
    logic        a;
    logic        v;
    i_pdsc_host_model.rd(code, d, a, v);
    `CHK(a, 1'b1)
    `CHK(v, 1'b0)
    `CHK(d, exp)
  endtask : chk_rd

  task automatic step(input logic up, input int n);
    @(posedge clock);
    {hl_step_up, lh_step_up} <= {2{up}};
    {hl_step_dn, lh_step_dn} <= {2{~up}};
    repeat (n) @(posedge clock);
    {hl_step_up, lh_step_up, hl_step_dn, lh_step_dn} <= 4'h0;
    repeat (2) @(posedge clock);
  endtask : step

  task automatic seq_en(input logic v);
    @(posedge clock);
    enable_req <= v;
    repeat (3) @(posedge clock);
  endtask : seq_en

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    final_report();
  end

  // ==========================================================================
  // tests
  initial begin
    logic [31:0] d;
    logic        a;
    logic        v;
    int          hl;
    int          lh;
    {hl_step_up, lh_step_up, hl_step_dn, lh_step_dn} = 4'h0;
    enable_req = 1'b0;
    checks     = 0;
    n_mismatch = 0;
    codes   = '{CMD_TEMP_CORR, CMD_GAP_TIMES, CMD_GAP_OPT, CMD_LOOP, CMD_ORDER};
    masks   = '{32'h0000_00FF, 32'h0000_FFFF, 32'h0000_FFFF, 32'h01FF_FFFF, 32'h0000_9F9F};
    exp_reg = '{32'h0000_0000, 32'h0000_3C3C, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    void'($urandom(92));
    rst_b = 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) chk_rd(codes[i], exp_reg[i]);
    i_pdsc_host_model.rd(8'h55, d, a, v);
    `CHK({a, v}, 2'b01)
    step(1'b1, 5);
    `CHK(hl_gap.ns, 8'sd60)
    $display("test reset done");

    for (int n = 0; n < 8; n++) begin
      for (int i = 0; i < 5; i++) begin
        d = $urandom();
        i_pdsc_host_model.wr(codes[i], d);
        exp_reg[i] = d & masks[i];
        chk_rd(codes[i], exp_reg[i]);
      end
      `CHK(coef_int, exp_reg[0][7] ? 7'h00 : exp_reg[0][6:0])
      `CHK(coef_ext0, exp_reg[0][7] ? exp_reg[0][6:0] : 7'h00)
      `CHK(coef_ext1, exp_reg[0][7] ? exp_reg[0][6:0] : 7'h00)
      `CHK(loop_en, exp_reg[3][24])
      `CHK({loop_residual, loop_gain}, exp_reg[3][23:0])
    end
    $display("test registers done");

    i_pdsc_host_model.wr(CMD_GAP_OPT, 32'h0000_8080);
    for (int n = 0; n < 6; n++) begin
      hl = (n == 0) ? -10 : int'($urandom_range(70)) - 10;
      lh = (n == 0) ? 60 : int'($urandom_range(70)) - 10;
      i_pdsc_host_model.wr(CMD_GAP_TIMES, {16'h0000, 8'(hl), 8'(lh)});
      step(n[0], 3);
      `CHK(hl_gap.ns, 8'(hl))
      `CHK(lh_gap.ns, 8'(lh))
      `CHK({hl_gap.overlap, lh_gap.overlap}, {hl < 0, lh < 0})
    end
    $display("test freeze done");

    i_pdsc_host_model.cap_max(16'h1E28, 16'h0A05);
    step(1'b1, 60);
    `CHK({hl_gap.ns, lh_gap.ns}, {8'sd30, 8'sd40})
    step(1'b0, 60);
    `CHK(hl_gap.ns, 8'sd20)
    `CHK(lh_gap.ns, 8'sd10)
    i_pdsc_host_model.wr(CMD_GAP_OPT, 32'h0000_0080);
    step(1'b0, 60);
    `CHK(hl_gap.ns, 8'sd0)
    `CHK(lh_gap.ns, 8'sd40)
    $display("test adaptive done");

    i_pdsc_host_model.wr(CMD_ORDER, 32'h0000_0305);
    seq_en(1'b1);
    `CHK(output_en, 1'b1)
    i_pdsc_host_model.evt(5'd5, 1'b0);
    repeat (3) @(posedge clock);
    `CHK(output_en, 1'b1)
    seq_en(1'b0);
    `CHK(output_en, 1'b0)
    i_pdsc_host_model.wr(CMD_ORDER, 32'h0000_8385);
    seq_en(1'b1);
    `CHK(output_en, 1'b0)
    i_pdsc_host_model.evt(5'd7, 1'b1);
    repeat (3) @(posedge clock);
    `CHK(output_en, 1'b0)
    i_pdsc_host_model.evt(5'd3, 1'b1);
    repeat (3) @(posedge clock);
    `CHK(output_en, 1'b1)
    i_pdsc_host_model.evt(5'd5, 1'b0);
    repeat (3) @(posedge clock);
    `CHK(output_en, 1'b0)
    seq_en(1'b0);
    $display("test sequencing done");
    final_report();
  end

endmodule : test_pdsc_cfg
